// >>> hdl/mcw_regs.svh
`ifndef MCW_REGS_SVH
`define MCW_REGS_SVH

// clock rate and blink timing
`define MCW_CLK_HZ          200000000
`define MCW_BLINK_HZ        4
// half period of the blink square wave, in clock cycles
`define MCW_BLINK_HALF_CYC  (`MCW_CLK_HZ / (2 * `MCW_BLINK_HZ))
// watchdog timeout width and its reset value
`define MCW_TMO_W           32
`define MCW_TMO_RST         32'h0098_9680
// number of drive power-enable outputs (six axes plus the CAN connector)
`define MCW_PWR_N           7

`endif

// >>> hdl/mcw_pkg.sv
`default_nettype none
package mcw_pkg;

   // watchdog supervisor states
   typedef enum logic [1:0] {
      MCW_WD_OFF,
      MCW_WD_RUN,
      MCW_WD_EXPIRED
   } mcw_wd_state_type;

   // expander bus led states
   typedef enum logic [1:0] {
      MCW_XB_IDLE,
      MCW_XB_INIT,
      MCW_XB_UP,
      MCW_XB_DROPPED
   } mcw_xb_state_type;

endpackage
`default_nettype wire

// >>> hdl/mcw_blink_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "mcw_regs.svh"

// free-running square wave shared by every blinking led
module mcw_blink_gen #(
   parameter int unsigned HALF_CYC = `MCW_BLINK_HALF_CYC
) (
   input  wire logic clock_i,
   input  wire logic sys_rst_i,
   output logic      blink_o
);

   logic [31:0] cnt_reg;   // cycles into the current half period

   // count half periods and toggle the wave at each end
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         cnt_reg <= 32'h0000_0000;
         blink_o <= 1'b0;
      end else if (cnt_reg >= 32'(HALF_CYC - 1)) begin
         cnt_reg <= 32'h0000_0000;
         blink_o <= ~blink_o;
      end else begin
         cnt_reg <= cnt_reg + 32'h0000_0001;
      end
   end

endmodule
`default_nettype wire

// >>> hdl/mcw_wd_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "mcw_regs.svh"

// host-serviced watchdog: counts clocks between service reads
module mcw_wd_timer #(
   parameter int unsigned TMO_W = `MCW_TMO_W
) (
   input  wire logic             clock_i,
   input  wire logic             sys_rst_i,
   input  wire logic             wd_enable_i,    // host enable setting
   input  wire logic             enable_wr_i,    // pulse: host rewrote the enable
   input  wire logic             service_i,      // pulse: host service read
   input  wire logic [TMO_W-1:0] timeout_i,      // interval in clock cycles
   output logic                  expired_o
);

   mcw_pkg::mcw_wd_state_type state_reg;
   mcw_pkg::mcw_wd_state_type state_next;
   logic [TMO_W-1:0]          cnt_reg;          // cycles since last service

   // next state of the supervisor
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         mcw_pkg::MCW_WD_OFF: begin
            if (wd_enable_i) begin
               state_next = mcw_pkg::MCW_WD_RUN;
            end
         end
         mcw_pkg::MCW_WD_RUN: begin
            if (!wd_enable_i) begin
               state_next = mcw_pkg::MCW_WD_OFF;
            end else if (!service_i && cnt_reg >= timeout_i) begin
               state_next = mcw_pkg::MCW_WD_EXPIRED;
            end
         end
         mcw_pkg::MCW_WD_EXPIRED: begin
            // only a rewrite of the enable releases the latch
            if (enable_wr_i) begin
               state_next = wd_enable_i ? mcw_pkg::MCW_WD_RUN : mcw_pkg::MCW_WD_OFF;
            end
         end
         default: begin
            state_next = mcw_pkg::MCW_WD_OFF;
         end
      endcase
   end

   // state register
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         state_reg <= mcw_pkg::MCW_WD_OFF;
      end else begin
         state_reg <= state_next;
      end
   end

   // interval counter, restarted by every service read
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         cnt_reg <= '0;
      end else if (service_i || state_next != mcw_pkg::MCW_WD_RUN || state_reg != mcw_pkg::MCW_WD_RUN) begin
         cnt_reg <= '0;
      end else if (cnt_reg != '1) begin
         cnt_reg <= cnt_reg + TMO_W'(1);   // saturates so a stalled host cannot wrap back under
      end
   end

   // registered expiry flag
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         expired_o <= 1'b0;
      end else begin
         expired_o <= (state_next == mcw_pkg::MCW_WD_EXPIRED);
      end
   end

endmodule
`default_nettype wire

// >>> hdl/mcw_card_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
`include "mcw_regs.svh"

// Contract
// - host service read restarts watchdog count
// - enable cleared means watchdog never expires
// - expire when no service within timeout
// - expired status flag is readable
// - expiry forces power enables low immediately
// - red led on expired, blink bus error
// - white led blinks while software runs
// - green led on after successful boot
// - can led blinks traffic, on when full
// - expander led blinks during module initialization
// - expander led on while all modules communicate
// - expander led off after module dropout
// - power on needs request, no expiry, no fault
module mcw_card_supervisor #(
   parameter int unsigned TMO_W     = `MCW_TMO_W,
   parameter int unsigned PWR_N     = `MCW_PWR_N,
   parameter int unsigned BLINK_CYC = `MCW_BLINK_HALF_CYC
) (
   input  wire logic             clock_i,
   input  wire logic             sys_rst_i,
   // host side controls
   input  wire logic             wd_enable_i,      // watchdog enable setting
   input  wire logic             wd_enable_wr_i,   // pulse when enable is written
   input  wire logic [TMO_W-1:0] wd_timeout_i,     // timeout in clock cycles
   input  wire logic             wd_service_i,     // pulse on host service read
   input  wire logic             power_req_i,      // host power-enable request
   input  wire logic             power_fault_i,    // external power fault, high = fault
   // card conditions for the leds
   input  wire logic             sw_running_i,     // host control software running
   input  wire logic             boot_done_i,      // card boot completed
   input  wire logic             bus_error_i,      // host bus communication error
   input  wire logic             can_traffic_i,    // can frame traffic seen
   input  wire logic             can_full_i,       // any can buffer full
   input  wire logic             xb_init_i,        // expander modules initializing
   input  wire logic             xb_all_ok_i,      // all initialized modules talk
   input  wire logic             xb_dropped_i,     // an initialized module dropped
   // outputs
   output logic                  wd_expired_o,     // watchdog expired status
   output logic [PWR_N-1:0]      power_en_o,       // drive power enables
   output logic                  led_fault_o,      // red
   output logic                  led_active_o,     // white
   output logic                  led_boot_o,       // green
   output logic                  led_can_o,        // orange, can
   output logic                  led_xbus_o        // orange, expander bus
);

   logic                      expired;      // watchdog expiry, registered in the timer
   logic                      blink;        // shared blink wave
   mcw_pkg::mcw_xb_state_type xb_reg;       // expander bus led state
   mcw_pkg::mcw_xb_state_type xb_next;

   // watchdog timer
   mcw_wd_timer #(
      .TMO_W       (TMO_W)
   ) u_wd (
      .clock_i     (clock_i),
      .sys_rst_i   (sys_rst_i),
      .wd_enable_i (wd_enable_i),
      .enable_wr_i (wd_enable_wr_i),
      .service_i   (wd_service_i),
      .timeout_i   (wd_timeout_i),
      .expired_o   (expired)
   );

   // one blink source keeps all leds in step
   mcw_blink_gen #(
      .HALF_CYC  (BLINK_CYC)
   ) u_blink (
      .clock_i   (clock_i),
      .sys_rst_i (sys_rst_i),
      .blink_o   (blink)
   );

   // status flag mirrors the timer's latched expiry
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         wd_expired_o <= 1'b0;
      end else begin
         wd_expired_o <= expired;
      end
   end

   // power enables; expiry acts here with no host involvement
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         power_en_o <= '0;
      end else if (power_req_i && !expired && !power_fault_i) begin
         power_en_o <= '1;
      end else begin
         power_en_o <= '0;
      end
   end

   // red led: expiry outranks bus errors
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         led_fault_o <= 1'b0;
      end else if (expired) begin
         led_fault_o <= 1'b1;
      end else if (bus_error_i) begin
         led_fault_o <= blink;
      end else begin
         led_fault_o <= 1'b0;
      end
   end

   // white and green leds
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         led_active_o <= 1'b0;
         led_boot_o   <= 1'b0;
      end else begin
         led_active_o <= sw_running_i & blink;
         led_boot_o   <= boot_done_i;
      end
   end

   // can led: a full buffer outranks traffic blinking
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         led_can_o <= 1'b0;
      end else if (can_full_i) begin
         led_can_o <= 1'b1;
      end else if (can_traffic_i) begin
         led_can_o <= blink;
      end else begin
         led_can_o <= 1'b0;
      end
   end

   // expander bus state; a dropout sticks until a new initialization
   always_comb begin
      xb_next = xb_reg;
      case (xb_reg)
         mcw_pkg::MCW_XB_IDLE: begin
            if (xb_init_i) begin
               xb_next = mcw_pkg::MCW_XB_INIT;
            end
         end
         mcw_pkg::MCW_XB_INIT: begin
            if (xb_dropped_i) begin
               xb_next = mcw_pkg::MCW_XB_DROPPED;
            end else if (!xb_init_i && xb_all_ok_i) begin
               xb_next = mcw_pkg::MCW_XB_UP;
            end
         end
         mcw_pkg::MCW_XB_UP: begin
            if (xb_dropped_i || !xb_all_ok_i) begin
               xb_next = mcw_pkg::MCW_XB_DROPPED;
            end else if (xb_init_i) begin
               xb_next = mcw_pkg::MCW_XB_INIT;
            end
         end
         mcw_pkg::MCW_XB_DROPPED: begin
            // limitation: only a fresh initialization clears a dropout
            if (xb_init_i && !xb_dropped_i) begin
               xb_next = mcw_pkg::MCW_XB_INIT;
            end
         end
         default: begin
            xb_next = mcw_pkg::MCW_XB_IDLE;
         end
      endcase
   end

   // expander state register
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         xb_reg <= mcw_pkg::MCW_XB_IDLE;
      end else begin
         xb_reg <= xb_next;
      end
   end

   // expander led from state
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         led_xbus_o <= 1'b0;
      end else begin
         case (xb_next)
            mcw_pkg::MCW_XB_INIT: begin
               led_xbus_o <= blink;
            end
            mcw_pkg::MCW_XB_UP: begin
               led_xbus_o <= 1'b1;
            end
            mcw_pkg::MCW_XB_DROPPED: begin
               led_xbus_o <= 1'b0;
            end
            default: begin
               led_xbus_o <= 1'b0;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// >>> bench/mcw_card_supervisor_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// watches the supervisor ports only
module mcw_card_supervisor_asserts #(
   parameter int unsigned TMO_W     = 32,
   parameter int unsigned PWR_N     = 7,
   parameter int unsigned BLINK_CYC = 4
) (
   input wire logic             clock_i,
   input wire logic             sys_rst_i,
   input wire logic             wd_enable_i,
   input wire logic             wd_enable_wr_i,
   input wire logic [TMO_W-1:0] wd_timeout_i,
   input wire logic             wd_service_i,
   input wire logic             power_req_i,
   input wire logic             power_fault_i,
   input wire logic             sw_running_i,
   input wire logic             boot_done_i,
   input wire logic             xb_dropped_i,
   input wire logic             wd_expired_o,
   input wire logic [PWR_N-1:0] power_en_o,
   input wire logic             led_fault_o,
   input wire logic             led_active_o,
   input wire logic             led_boot_o,
   input wire logic             led_xbus_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   pwr_gate_a: assert property (power_en_o != '0 |-> (&power_en_o) && $past(power_req_i)
      && !$past(power_fault_i) && !wd_expired_o) else $error("power on without cause");
   exp_low_a: assert property (wd_expired_o |-> power_en_o == '0)
      else $error("power on while expired");
   // release is only by a write, so a fall needs one shortly before
   exp_hold_a: assert property ($fell(wd_expired_o) |-> $past(wd_enable_wr_i)
      || $past(wd_enable_wr_i, 2) || $past(wd_enable_wr_i, 3)) else $error("expiry dropped");
   exp_cause_a: assert property ($rose(wd_expired_o) |-> $past(wd_enable_i)
      || $past(wd_enable_i, 2)) else $error("expiry while disabled");
   svc_restart_a: assert property (wd_service_i && wd_timeout_i > 32'h8
      |-> ##3 (!$rose(wd_expired_o)) [*4]) else $error("expiry soon after service");
   red_exp_a: assert property (wd_expired_o && $past(wd_expired_o) |-> led_fault_o)
      else $error("red led not on");
   boot_led_a: assert property (!$past(sys_rst_i) |-> led_boot_o == $past(boot_done_i))
      else $error("green led wrong");
   // a half period apart the blink phase must differ
   act_blink_a: assert property (sw_running_i [*8] |-> led_active_o != $past(led_active_o, BLINK_CYC))
      else $error("white led not blinking");
   xb_drop_a: assert property ($past(xb_dropped_i) && $past(xb_dropped_i, 2) |-> !led_xbus_o)
      else $error("expander led on after drop");
endmodule
bind mcw_card_supervisor mcw_card_supervisor_asserts #(.TMO_W(TMO_W), .PWR_N(PWR_N), .BLINK_CYC(BLINK_CYC)) chk_u (
   .clock_i(clock_i), .sys_rst_i(sys_rst_i), .wd_enable_i(wd_enable_i), .wd_enable_wr_i(wd_enable_wr_i),
   .wd_timeout_i(wd_timeout_i), .wd_service_i(wd_service_i), .power_req_i(power_req_i),
   .power_fault_i(power_fault_i), .sw_running_i(sw_running_i), .boot_done_i(boot_done_i),
   .xb_dropped_i(xb_dropped_i), .wd_expired_o(wd_expired_o), .power_en_o(power_en_o),
   .led_fault_o(led_fault_o), .led_active_o(led_active_o), .led_boot_o(led_boot_o), .led_xbus_o(led_xbus_o));
`default_nettype wire

// >>> bench/mcw_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host driver stand-in: periodic service read
module mcw_host_model #(
   parameter int unsigned PER = 5
) (
   input  wire logic   clock_i,
   input  wire logic   sys_rst_i,
   input  wire logic   run_i,
   output logic        svc_o,
   output logic [31:0] tmo_o
);
   int cnt = 0;                    // cycles since last read
   assign tmo_o = 32'(3 * PER);
   initial svc_o = 1'b0;
   // one read pulse each period, driven off the sampling edge
   always @(negedge clock_i) begin
      cnt = (sys_rst_i || !run_i || cnt == PER - 1) ? 0 : cnt + 1;
      svc_o <= run_i && !sys_rst_i && cnt == 0;
   end
endmodule
`default_nettype wire

// >>> bench/mcw_card_supervisor_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module mcw_card_supervisor_tb_top;
   logic        clock_i = 1'b0;   // 200 mhz
   logic        sys_rst_i = 1'b1;
   logic        en = 1'b0, wr = 1'b0, req = 1'b0, flt = 1'b0, run = 1'b0;
   logic        sw = 1'b0, boot = 1'b0, berr = 1'b0, ctr = 1'b0, cfull = 1'b0;
   logic        xi = 1'b0, xok = 1'b0, xd = 1'b0;
   logic        svc, wdx, lf, la, lb, lc, lx;
   logic [31:0] tmo;
   logic [6:0]  pwr;
   int          mismatches = 0, n_checks = 0, ta, tf, tc, tx, k;
   always #2.5 clock_i = ~clock_i;
   mcw_host_model #(.PER(5)) host_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .run_i(run), .svc_o(svc),
      .tmo_o(tmo));
   // short blink keeps the run brief
   mcw_card_supervisor #(.TMO_W(32), .PWR_N(7), .BLINK_CYC(4)) dut_u (
      .clock_i(clock_i), .sys_rst_i(sys_rst_i), .wd_enable_i(en), .wd_enable_wr_i(wr),
      .wd_timeout_i(tmo), .wd_service_i(svc), .power_req_i(req), .power_fault_i(flt),
      .sw_running_i(sw), .boot_done_i(boot), .bus_error_i(berr), .can_traffic_i(ctr),
      .can_full_i(cfull), .xb_init_i(xi), .xb_all_ok_i(xok), .xb_dropped_i(xd),
      .wd_expired_o(wdx), .power_en_o(pwr), .led_fault_o(lf), .led_active_o(la),
      .led_boot_o(lb), .led_can_o(lc), .led_xbus_o(lx));
   task automatic cyc(input int n);
      repeat (n) @(negedge clock_i);
   endtask
   task automatic chk(input string nm, input logic [6:0] e, input logic [6:0] g);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // count led edges over n cycles
   task automatic tog(input int n);
      logic [3:0] p;
      p = {la, lf, lc, lx};
      {ta, tf, tc, tx} = '0;
      for (int i = 0; i < n; i++) begin
         cyc(1);
         ta += int'(la !== p[3]);
         tf += int'(lf !== p[2]);
         tc += int'(lc !== p[1]);
         tx += int'(lx !== p[0]);
         p = {la, lf, lc, lx};
      end
   endtask
   task automatic pulse_wr;
      wr = 1'b1;
      cyc(1);
      wr = 1'b0;
   endtask
   task automatic t_watch;
      en = 1'b1;
      req = 1'b1;
      pulse_wr();
      run = 1'b1;
      cyc(60);
      chk("expired", 7'h00, 7'(wdx));
      run = 1'b0;
      k = 0;
      while (wdx !== 1'b1 && k < 40) begin
         cyc(1);
         k++;
      end
      chk("expiry_time", 7'h01, 7'(k >= 12 && k <= 25));
      chk("expired", 7'h01, 7'(wdx));
      chk("power", 7'h00, pwr);
      cyc(1);
      chk("red_led", 7'h01, 7'(lf));
      run = 1'b1;
      cyc(20);
      chk("expired_held", 7'h01, 7'(wdx));
      pulse_wr();
      cyc(4);
      chk("expired", 7'h00, 7'(wdx));
      chk("power", 7'h7F, pwr);
   endtask
   task automatic t_off;
      en = 1'b0;
      run = 1'b0;
      cyc(60);
      chk("expired_off", 7'h00, 7'(wdx));
      chk("power_off", 7'h7F, pwr);
   endtask
   task automatic t_power;
      for (int i = 0; i < 4; i++) begin
         req = i[0];
         flt = i[1];
         cyc(2);
         chk("power_gate", (i == 1) ? 7'h7F : 7'h00, pwr);
      end
   endtask
   task automatic t_leds;
      {sw, boot, berr, ctr} = 4'hF;
      cyc(4);
      tog(32);
      chk("white_edges", 7'h08, 7'(ta));
      chk("red_edges", 7'h08, 7'(tf));
      chk("can_edges", 7'h08, 7'(tc));
      chk("green", 7'h01, 7'(lb));
      cfull = 1'b1;
      cyc(2);
      chk("can_full", 7'h01, 7'(lc));
      {sw, boot, berr, ctr, cfull} = 5'h00;
      cyc(2);
      chk("leds_off", 7'h00, 7'({la, lf, lb, lc}));
   endtask
   task automatic t_xbus;
      xi = 1'b1;
      cyc(4);
      tog(16);
      chk("xbus_edges", 7'h04, 7'(tx));
      xi = 1'b0;
      xok = 1'b1;
      cyc(3);
      chk("xbus_up", 7'h01, 7'(lx));
      xd = 1'b1;
      cyc(3);
      chk("xbus_drop", 7'h00, 7'(lx));
      xd = 1'b0;
      cyc(3);
      chk("xbus_stays", 7'h00, 7'(lx));
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clock_i);
      @(negedge clock_i);
      sys_rst_i = 1'b0;
      t_watch();
      t_off();
      t_power();
      t_leds();
      t_xbus();
      conclude();
   end
   // hang guard, well past the few hundred cycles needed
   initial begin
      #20000;
      mismatches++;
      conclude();
   end
endmodule
`default_nettype wire
